// [hw/sdac_pkg.sv]
// Purpose: Shared constants of the delta-sigma converter control block.
// Assumes: Byte-wide register port, registers at their printed offsets.
// Notes:   Every offset, field position, control reset value and filter ratio lives here.
package sdac_pkg;
  // Register offsets
  localparam logic [7:0] SDAC_OFF_RESULT_LOW  = 8'h04;
  localparam logic [7:0] SDAC_OFF_RESULT_MID  = 8'h05;
  localparam logic [7:0] SDAC_OFF_RESULT_HIGH = 8'h06;
  localparam logic [7:0] SDAC_OFF_CTRL0       = 8'h07;
  localparam logic [7:0] SDAC_OFF_CTRL1       = 8'h08;
  localparam logic [7:0] SDAC_OFF_CLK_DIV     = 8'h09;
  localparam logic [7:0] SDAC_OFF_TRIM        = 8'h0a;

  // Reset values
  localparam logic [7:0] SDAC_RST_CTRL0   = 8'h20;
  localparam logic [7:0] SDAC_RST_CTRL1   = 8'h00;
  localparam logic [4:0] SDAC_RST_CLK_DIV = 5'h00;
  localparam logic [7:0] SDAC_RST_TRIM    = 8'he4;

  // Control register 0 fields
  localparam int SDAC_C0_SOFT_RESET = 7;
  localparam int SDAC_C0_SLEEP      = 6;
  localparam int SDAC_C0_POWER_OFF  = 5;
  localparam int SDAC_C0_OSR_MSB    = 4;
  localparam int SDAC_C0_OSR_LSB    = 1;
  localparam int SDAC_C0_REF_SEL    = 0;

  // Control register 1 fields
  localparam int SDAC_C1_FILT_MSB = 7;
  localparam int SDAC_C1_FILT_LSB = 5;
  localparam int SDAC_C1_BUF_NEG  = 4;
  localparam int SDAC_C1_BUF_POS  = 3;
  localparam int SDAC_C1_HOLD     = 2;
  localparam int SDAC_C1_DONE     = 1;

  // Clock divider field
  localparam int         SDAC_DIV_MSB    = 4;
  localparam logic [4:0] SDAC_DIV_BYPASS = 5'h1f;

  // Filter clock ratio codes and ratios
  localparam logic [2:0] SDAC_FILT_CODE_30 = 3'h0;
  localparam logic [2:0] SDAC_FILT_CODE_12 = 3'h2;
  localparam logic [4:0] SDAC_FILT_LAST_30 = 5'h1d;
  localparam logic [4:0] SDAC_FILT_LAST_12 = 5'h0b;

  // Oversampling: code 0 gives 2^15, code 8 gives 2^7
  localparam logic [3:0] SDAC_OSR_CODE_MAX = 4'h8;
  localparam int         SDAC_OSR_LOG_TOP  = 15;

  // Result format
  localparam int          SDAC_RESULT_WIDTH = 24;
  localparam int          SDAC_SCALE_BASE   = 8;
  localparam logic [23:0] SDAC_RESULT_MAX   = 24'h7fffff;
  localparam logic [23:0] SDAC_RESULT_MIN   = 24'h800000;
endpackage : sdac_pkg

// [hw/sdac_buf2.sv]
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Full and empty are exact; no word is dropped on a stall.
`timescale 1ns/100ps
module sdac_buf2 #(
  parameter int WIDTH = 24
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] store [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             next_wr_ptr;
  logic             next_rd_ptr;
  logic [1:0]       next_count;
  logic             push;
  logic             pop;

  // Handshakes and pointer arithmetic
  always_comb
  begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count  = count;
    if (push && !pop)
    begin
      next_count = count + 2'h1;
    end
    else if (pop && !push)
    begin
      next_count = count - 2'h1;
    end
  end

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = store[rd_ptr];

  // Storage has no reset; valid words are tracked by count
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointer state
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule : sdac_buf2

// [hw/sdac_ctrl.sv]
// Purpose: Digital control of a 24-bit delta-sigma converter.
// Assumes: Byte register port driven by the serial slave, one clock.
// Notes:   Modulator bitstream arrives from the analog side, unsynchronised.
`timescale 1ns/100ps
module sdac_ctrl
  import sdac_pkg::*;
#(
  parameter int RESULT_WIDTH = sdac_pkg::SDAC_RESULT_WIDTH
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       mod_bit_in,
  output logic            modulator_clock_en,
  output logic            filter_clock_en,
  output logic            modulator_power,
  output logic            filter_power,
  output logic            gain_stage_power,
  output logic            ref_buf_pos_en,
  output logic            ref_buf_neg_en,
  output logic            reference_pair_sel,
  output logic            filter_in_reset
);
  import sdac_pkg::*;

  typedef enum logic [1:0] {
    SDAC_POWER_DOWN,
    SDAC_SLEEP,
    SDAC_FILTER_RESET,
    SDAC_NORMAL
  } sdac_mode_type;

  // Register state
  logic [7:0]              converter_ctrl_reg0;
  logic [7:0]              converter_ctrl_reg1;
  logic [4:0]              modulator_clock_divider;
  logic [7:0]              fixed_trim_value;
  logic [RESULT_WIDTH-1:0] result_word;
  logic [7:0]              next_ctrl0;
  logic [7:0]              next_ctrl1;
  logic [4:0]              next_clk_div;
  logic [7:0]              next_trim;
  logic [RESULT_WIDTH-1:0] next_result;
  logic [7:0]              next_rdata;

  // Field views
  logic       converter_power_off;
  logic       converter_sleep_sel;
  logic       filter_soft_reset;
  logic [3:0] oversample_ratio_sel;
  logic [2:0] filter_clock_ratio_sel;
  logic       result_hold_enable;
  logic [4:0] modulator_clock_div_sel;

  // Mode and start state
  sdac_mode_type mode;
  sdac_mode_type next_mode;
  logic          started;
  logic          next_started;
  logic          soft_reset_seen;
  logic          active;

  // Clock enables
  logic [5:0] mod_cnt;
  logic [5:0] next_mod_cnt;
  logic [5:0] mod_last;
  logic       next_mod_tick;
  logic [4:0] filt_cnt;
  logic [4:0] next_filt_cnt;
  logic [4:0] filt_last;
  logic       next_filt_tick;

  // Decimator
  logic                    mod_bit_meta;
  logic                    mod_bit_sync;
  logic [3:0]              osr_code;
  logic [15:0]             osr_last;
  logic [15:0]             osr_cnt;
  logic [15:0]             next_osr_cnt;
  logic signed [16:0]      acc;
  logic signed [16:0]      next_acc;
  logic signed [16:0]      acc_final;
  logic signed [31:0]      scaled;
  logic [RESULT_WIDTH-1:0] clamped;
  logic                    pend_valid;
  logic                    next_pend_valid;
  logic [RESULT_WIDTH-1:0] pend_data;
  logic [RESULT_WIDTH-1:0] next_pend_data;
  logic                    pend_ready;
  logic                    drain_valid;
  logic                    drain_ready;
  logic [RESULT_WIDTH-1:0] drain_data;
  logic                    result_taken;
  logic                    result_read;

  assign converter_power_off     = converter_ctrl_reg0[SDAC_C0_POWER_OFF];
  assign converter_sleep_sel     = converter_ctrl_reg0[SDAC_C0_SLEEP];
  assign filter_soft_reset       = converter_ctrl_reg0[SDAC_C0_SOFT_RESET];
  assign oversample_ratio_sel    =
    converter_ctrl_reg0[SDAC_C0_OSR_MSB:SDAC_C0_OSR_LSB];
  assign filter_clock_ratio_sel  =
    converter_ctrl_reg1[SDAC_C1_FILT_MSB:SDAC_C1_FILT_LSB];
  assign result_hold_enable      = converter_ctrl_reg1[SDAC_C1_HOLD];
  assign modulator_clock_div_sel = modulator_clock_divider;

  // Mode decode; power-off wins, then sleep, then filter reset
  always_comb
  begin
    if (converter_power_off)
    begin
      next_mode = SDAC_POWER_DOWN;
    end
    else if (converter_sleep_sel)
    begin
      next_mode = SDAC_SLEEP;
    end
    else if (filter_soft_reset)
    begin
      next_mode = SDAC_FILTER_RESET;
    end
    else
    begin
      next_mode = SDAC_NORMAL;
    end
    // Armed only by a falling filter-reset while powered
    next_started = started;
    if (mode == SDAC_POWER_DOWN)
    begin
      next_started = 1'b0;
    end
    else if (mode == SDAC_FILTER_RESET && next_mode == SDAC_NORMAL)
    begin
      next_started = 1'b1;
    end
  end

  assign soft_reset_seen = started;
  assign active          = (mode == SDAC_NORMAL) && soft_reset_seen;

  // Mode registers and analog power controls
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode               <= SDAC_POWER_DOWN;
      started            <= 1'b0;
      modulator_power    <= 1'b0;
      filter_power       <= 1'b0;
      gain_stage_power   <= 1'b0;
      ref_buf_pos_en     <= 1'b0;
      ref_buf_neg_en     <= 1'b0;
      reference_pair_sel <= 1'b0;
      filter_in_reset    <= 1'b0;
    end
    else
    begin
      mode               <= next_mode;
      started            <= next_started;
      modulator_power    <= (next_mode == SDAC_NORMAL) ||
                            (next_mode == SDAC_FILTER_RESET);
      filter_power       <= (next_mode != SDAC_POWER_DOWN);
      gain_stage_power   <= (next_mode != SDAC_POWER_DOWN);
      ref_buf_pos_en     <= modulator_power_ok(next_mode) &&
                            converter_ctrl_reg1[SDAC_C1_BUF_POS];
      ref_buf_neg_en     <= modulator_power_ok(next_mode) &&
                            converter_ctrl_reg1[SDAC_C1_BUF_NEG];
      reference_pair_sel <= converter_ctrl_reg0[SDAC_C0_REF_SEL];
      filter_in_reset    <= (next_mode == SDAC_FILTER_RESET);
    end
  end

  function automatic logic modulator_power_ok(input sdac_mode_type m);
    modulator_power_ok = (m == SDAC_NORMAL) || (m == SDAC_FILTER_RESET);
  endfunction : modulator_power_ok

  // Clock enable dividers; ticks stop outside conversion
  always_comb
  begin
    mod_last       = {modulator_clock_div_sel, 1'b1};
    next_mod_cnt   = mod_cnt + 6'h01;
    next_mod_tick  = 1'b0;
    if (modulator_clock_div_sel == SDAC_DIV_BYPASS || mod_cnt >= mod_last)
    begin
      next_mod_cnt  = 6'h00;
      next_mod_tick = 1'b1;
    end
    // Reserved ratio codes fall back to the divide-by-30 setting
    filt_last = (filter_clock_ratio_sel == SDAC_FILT_CODE_12) ?
                SDAC_FILT_LAST_12 : SDAC_FILT_LAST_30;
    next_filt_cnt  = filt_cnt;
    next_filt_tick = 1'b0;
    if (modulator_clock_en)
    begin
      next_filt_cnt = filt_cnt + 5'h01;
      if (filt_cnt >= filt_last)
      begin
        next_filt_cnt  = 5'h00;
        next_filt_tick = 1'b1;
      end
    end
    if (!active)
    begin
      next_mod_cnt   = 6'h00;
      next_mod_tick  = 1'b0;
      next_filt_cnt  = 5'h00;
      next_filt_tick = 1'b0;
    end
  end

  // Divider registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mod_cnt            <= 6'h00;
      modulator_clock_en <= 1'b0;
      filt_cnt           <= 5'h00;
      filter_clock_en    <= 1'b0;
    end
    else
    begin
      mod_cnt            <= next_mod_cnt;
      modulator_clock_en <= next_mod_tick;
      filt_cnt           <= next_filt_cnt;
      filter_clock_en    <= next_filt_tick;
    end
  end

  // Bitstream crosses from the analog side
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mod_bit_meta <= 1'b0;
      mod_bit_sync <= 1'b0;
    end
    else
    begin
      mod_bit_meta <= mod_bit_in;
      mod_bit_sync <= mod_bit_meta;
    end
  end

  // Decimation: sum of +/-1 over the ratio, scaled to 24 bits
  always_comb
  begin
    osr_code = (oversample_ratio_sel > SDAC_OSR_CODE_MAX) ?
               SDAC_OSR_CODE_MAX : oversample_ratio_sel;
    osr_last = 16'((32'h1 << (SDAC_OSR_LOG_TOP - int'(osr_code))) - 1);
    acc_final = acc + (mod_bit_sync ? 17'sd1 : -17'sd1);
    // Shift by 8 + code makes a full-scale sum hit 2^23
    scaled = 32'(acc_final) <<< (SDAC_SCALE_BASE + int'(osr_code));
    if (scaled > 32'(signed'(SDAC_RESULT_MAX)))
    begin
      clamped = SDAC_RESULT_MAX;
    end
    else if (scaled < 32'(signed'(SDAC_RESULT_MIN)))
    begin
      clamped = SDAC_RESULT_MIN;
    end
    else
    begin
      clamped = scaled[RESULT_WIDTH-1:0];
    end
    next_acc        = acc;
    next_osr_cnt    = osr_cnt;
    next_pend_valid = pend_valid && !pend_ready;
    next_pend_data  = pend_data;
    // A full buffer with a pending word stalls accumulation
    if (filter_clock_en && !(pend_valid && !pend_ready))
    begin
      if (osr_cnt >= osr_last)
      begin
        next_acc        = 17'sd0;
        next_osr_cnt    = 16'h0000;
        next_pend_valid = 1'b1;
        next_pend_data  = clamped;
      end
      else
      begin
        next_acc     = acc_final;
        next_osr_cnt = osr_cnt + 16'h0001;
      end
    end
    if (!active)
    begin
      next_acc     = 17'sd0;
      next_osr_cnt = 16'h0000;
    end
  end

  // Decimator registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc        <= 17'sd0;
      osr_cnt    <= 16'h0000;
      pend_valid <= 1'b0;
      pend_data  <= '0;
    end
    else
    begin
      acc        <= next_acc;
      osr_cnt    <= next_osr_cnt;
      pend_valid <= next_pend_valid;
      pend_data  <= next_pend_data;
    end
  end

  // Finished results wait here while a result read is under way
  sdac_buf2 #(
    .WIDTH (RESULT_WIDTH)
  ) u_sdac_buf2 (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (pend_valid),
    .in_ready  (pend_ready),
    .in_data   (pend_data),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_data)
  );

  // Drain stalls in each result byte read cycle only; a new word can land between the byte reads
  assign result_read  = reg_rd && (reg_addr == SDAC_OFF_RESULT_LOW ||
                        reg_addr == SDAC_OFF_RESULT_MID ||
                        reg_addr == SDAC_OFF_RESULT_HIGH);
  assign drain_ready  = !result_read;
  assign result_taken = drain_valid && drain_ready &&
                        !result_hold_enable;

  // Register writes, result update and done flag
  always_comb
  begin
    next_ctrl0   = converter_ctrl_reg0;
    next_ctrl1   = converter_ctrl_reg1;
    next_clk_div = modulator_clock_divider;
    next_trim    = fixed_trim_value;
    next_result  = result_word;
    if (reg_wr)
    begin
      case (reg_addr)
        SDAC_OFF_CTRL0:    next_ctrl0   = reg_wdata;
        SDAC_OFF_CTRL1:    next_ctrl1   = {reg_wdata[7:1], 1'b0};
        SDAC_OFF_CLK_DIV:  next_clk_div = reg_wdata[SDAC_DIV_MSB:0];
        SDAC_OFF_TRIM:     next_trim    = reg_wdata;
        default:           next_ctrl0   = converter_ctrl_reg0;
      endcase
    end
    if (result_taken)
    begin
      next_result = drain_data;
    end
    // Held result is kept; drained words are dropped
    // Hardware set beats a host clear in the same cycle
    if (result_taken)
    begin
      next_ctrl1[SDAC_C1_DONE] = 1'b1;
    end
    else if (reg_wr && reg_addr == SDAC_OFF_CTRL1)
    begin
      next_ctrl1[SDAC_C1_DONE] = reg_wdata[SDAC_C1_DONE];
    end
    next_rdata = reg_rdata;
    if (reg_rd)
    begin
      case (reg_addr)
        SDAC_OFF_RESULT_LOW:  next_rdata = result_word[7:0];
        SDAC_OFF_RESULT_MID:  next_rdata = result_word[15:8];
        SDAC_OFF_RESULT_HIGH: next_rdata = result_word[23:16];
        SDAC_OFF_CTRL0:       next_rdata = converter_ctrl_reg0;
        SDAC_OFF_CTRL1:       next_rdata = converter_ctrl_reg1;
        SDAC_OFF_CLK_DIV:     next_rdata = {3'h0, modulator_clock_divider};
        SDAC_OFF_TRIM:        next_rdata = fixed_trim_value;
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  // Register file
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      converter_ctrl_reg0     <= SDAC_RST_CTRL0;
      converter_ctrl_reg1     <= SDAC_RST_CTRL1;
      modulator_clock_divider <= SDAC_RST_CLK_DIV;
      fixed_trim_value        <= SDAC_RST_TRIM;
      result_word             <= '0;
      reg_rdata               <= 8'h00;
    end
    else
    begin
      converter_ctrl_reg0     <= next_ctrl0;
      converter_ctrl_reg1     <= next_ctrl1;
      modulator_clock_divider <= next_clk_div;
      fixed_trim_value        <= next_trim;
      result_word             <= next_result;
      reg_rdata               <= next_rdata;
    end
  end
endmodule : sdac_ctrl

// [dv/sdac_ctrl_properties.sv]
// Purpose: Port assertions for the converter control block.
// Assumes: Mode outputs settle one edge after the control word.
// Notes:   A mirror of ctrl0 stands in for the hidden register.
`timescale 1ns/100ps
module sdac_ctrl_properties
  import sdac_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       modulator_clock_en,
  input wire logic       filter_clock_en,
  input wire logic       modulator_power,
  input wire logic       filter_power,
  input wire logic       gain_stage_power,
  input wire logic       ref_buf_pos_en,
  input wire logic       ref_buf_neg_en,
  input wire logic       reference_pair_sel,
  input wire logic       filter_in_reset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic       rdp, seen, next_seen;
  logic [7:0] c0q, next_c0q;
  // Mirror ctrl0; note a done flag once read high
  always_comb
  begin
    next_c0q  = (reg_wr && reg_addr == SDAC_OFF_CTRL0) ? reg_wdata : c0q;
    next_seen = seen | (rdp & reg_rdata[1]);
    if (reg_wr && reg_addr == SDAC_OFF_CTRL1)
      next_seen = 1'b0;
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      c0q  <= SDAC_RST_CTRL0;
      rdp  <= 1'b0;
      seen <= 1'b0;
    end
    else
    begin
      c0q  <= next_c0q;
      rdp  <= reg_rd && reg_addr == SDAC_OFF_CTRL1;
      seen <= next_seen;
    end
  end
  AST_POWER_DOWN: assert property ($stable(c0q) && c0q[5] |->
    !(modulator_power | filter_power | gain_stage_power | ref_buf_pos_en
    | ref_buf_neg_en | filter_in_reset)) else $error("power-down leaks");
  AST_SLEEP_KEEPS: assert property (
    $stable(c0q) && c0q[6:5] == 2'b10 |-> !modulator_power && filter_power
    && gain_stage_power && !filter_in_reset) else $error("sleep levels");
  AST_RUN_POWER: assert property (
    $stable(c0q) && c0q[6:5] == 2'b00 |-> modulator_power && filter_power
    && gain_stage_power) else $error("run mode power off");
  AST_FILTER_RESET: assert property (
    $stable(c0q) |-> filter_in_reset == (c0q[7:5] == 3'b100))
    else $error("filter reset level wrong");
  AST_REF_SEL: assert property (
    $stable(c0q) |-> reference_pair_sel == c0q[0])
    else $error("reference select wrong");
  AST_FILT_PULSE: assert property (
    filter_clock_en |=> !filter_clock_en) else $error("filter tick long");
  AST_MOD_STOP: assert property (
    modulator_clock_en || filter_clock_en |->
    modulator_power || $past(modulator_power)) else $error("tick unpowered");
  AST_DIV_READ: assert property (
    reg_rd && reg_addr == SDAC_OFF_CLK_DIV |=> reg_rdata[7:5] == 3'h0)
    else $error("divider top bits not zero");
  AST_DONE_STAYS: assert property (
    reg_rd && reg_addr == SDAC_OFF_CTRL1 && seen |=> reg_rdata[1])
    else $error("done flag dropped by itself");
endmodule : sdac_ctrl_properties

bind sdac_ctrl sdac_ctrl_properties u_sdac_ctrl_properties (
  .ref_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
  .modulator_clock_en, .filter_clock_en, .modulator_power, .filter_power,
  .gain_stage_power, .ref_buf_pos_en, .ref_buf_neg_en, .reference_pair_sel,
  .filter_in_reset);

// [dv/sdac_mod_model.sv]
// Purpose: Behavioural modulator bitstream for the control bench.
// Assumes: A new bit on each modulator tick while powered.
// Notes:   Unpowered, the line toggles so no stale level passes.
`timescale 1ns/100ps
module sdac_mod_model (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic modulator_clock_en,
  input  wire logic modulator_power,
  input  wire logic level,
  output logic      mod_bit_in
);
  logic next_bit;
  // Level follows the input only on ticks while powered
  always_comb
  begin
    next_bit = ~mod_bit_in;
    if (modulator_power)
      next_bit = modulator_clock_en ? level : mod_bit_in;
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      mod_bit_in <= 1'b0;
    else
      mod_bit_in <= next_bit;
  end
endmodule : sdac_mod_model

// [dv/tb_sdac_ctrl.sv]
// Purpose: Self-checking bench for the converter control block.
// Assumes: Code 31, N of 12, oversampling 128 give 1536 clocks a result.
// Notes:   Read answers are checked against a queue by a monitor.
`timescale 1ns/100ps
module tb_sdac_ctrl;
  import sdac_pkg::*;
  logic       ref_clk, reset_n, reg_wr, reg_rd, level, want, arm;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got, d;
  logic       mod_bit_in, modulator_clock_en, filter_clock_en;
  logic       modulator_power, filter_power, gain_stage_power;
  logic       ref_buf_pos_en, ref_buf_neg_en, reference_pair_sel;
  logic       filter_in_reset;
  logic [7:0] exp_q[$];
  int         fails, checks_done, seed, n, i;
  int         per [5] = '{1536, 3072, 3840, 3072, 1536};
  sdac_ctrl u_sdac_ctrl (.ref_clk, .reset_n, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .mod_bit_in, .modulator_clock_en,
    .filter_clock_en, .modulator_power, .filter_power, .gain_stage_power,
    .ref_buf_pos_en, .ref_buf_neg_en, .reference_pair_sel,
    .filter_in_reset);
  sdac_mod_model u_sdac_mod_model (.ref_clk, .reset_n, .modulator_clock_en,
    .modulator_power, .level, .mod_bit_in);
  // Free-running system clock
  always #12.5 ref_clk = ~ref_clk;
  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  // Idle edge after each access so a strobe is never set twice at once
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e, logic c);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    want     <= c;
    if (c)
      exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    got = reg_rdata;
    @(posedge ref_clk);
  endtask : rd
  task automatic rd_res(logic [23:0] r);
    rd(SDAC_OFF_RESULT_LOW, r[7:0], 1'b1);
    rd(SDAC_OFF_RESULT_MID, r[15:8], 1'b1);
    rd(SDAC_OFF_RESULT_HIGH, r[23:16], 1'b1);
  endtask : rd_res
  // Poll done flag, bounded; n counts polls of two clocks each
  task automatic wait_done();
    n   = 0;
    got = 8'h00;
    while (got[1] !== 1'b1)
    begin
      rd(SDAC_OFF_CTRL1, 8'h00, 1'b0);
      n++;
      if (n > 3000)
      begin
        fails++;
        finish_test();
      end
    end
  endtask : wait_done
  // Monitor: a checked answer is settled by the next falling edge
  always @(posedge ref_clk)
    arm <= reg_rd && want;
  always @(negedge ref_clk)
    if (arm)
      chk("read data", exp_q.pop_front(), reg_rdata);
  initial
  begin
    {ref_clk, reset_n, reg_wr, reg_rd, want, arm} = 6'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    {level, fails, checks_done, seed} = {1'b1, 32'h0, 32'h0, 32'hd819e32f};
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    for (i = 0; i < 8; i++) // Reset values, unmapped 0x0f last
      rd(64'h04050607_08090a0f >> (56 - 8 * i),
         64'h00000020_0000e400 >> (56 - 8 * i), 1'b1);
    wr(SDAC_OFF_CLK_DIV, 8'hff);
    rd(SDAC_OFF_CLK_DIV, 8'h1f, 1'b1);
    d = 8'($random(seed));
    wr(SDAC_OFF_TRIM, d);
    rd(SDAC_OFF_TRIM, d, 1'b1);
    wr(SDAC_OFF_TRIM, 8'he7);
    wr(SDAC_OFF_RESULT_LOW, 8'h5a);
    rd(SDAC_OFF_RESULT_LOW, 8'h00, 1'b1);
    // Powered up but never pulsed: no conversion may finish
    wr(SDAC_OFF_CTRL1, 8'h40);
    wr(SDAC_OFF_CTRL0, 8'h10);
    repeat (2000) @(posedge ref_clk);
    rd(SDAC_OFF_CTRL1, 8'h40, 1'b1);
    wr(SDAC_OFF_CTRL0, 8'h90);
    wr(SDAC_OFF_CTRL0, 8'h10);
    wait_done();
    rd_res(24'h7fffff);
    // Period per divider, ratio and oversampling code; last code reserved
    for (i = 0; i < 5; i++)
    begin
      wr(SDAC_OFF_CLK_DIV, 40'h1f_00_1f_1f_1f >> (32 - 8 * i));
      wr(SDAC_OFF_CTRL0, 40'h10_10_10_0e_1e >> (32 - 8 * i));
      wr(SDAC_OFF_CTRL1, 40'h40_40_00_40_40 >> (32 - 8 * i));
      wait_done();
      wr(SDAC_OFF_CTRL1, 40'h40_40_00_40_40 >> (32 - 8 * i));
      wait_done();
      chk("period", 1, 2 * n inside {[per[i] - 12 : per[i] + 4]});
    end
    level <= 1'b0;
    wr(SDAC_OFF_CTRL1, 8'h40);
    wait_done();
    wr(SDAC_OFF_CTRL1, 8'h40);
    wait_done();
    rd_res(24'h800000);
    // Holding keeps the old word and the cleared flag
    level <= 1'b1;
    wr(SDAC_OFF_CTRL1, 8'h44);
    repeat (3200) @(posedge ref_clk);
    rd(SDAC_OFF_CTRL1, 8'h44, 1'b1);
    rd_res(24'h800000);
    wr(SDAC_OFF_CTRL1, 8'h40);
    wait_done();
    rd_res(24'h7fffff);
    for (i = 0; i < 5; i++) // Modes: off, off+sleep, sleep, reset, run
    begin
      wr(SDAC_OFF_CTRL0, 40'h30_70_50_90_11 >> (32 - 8 * i));
      repeat (10) @(posedge ref_clk);
      wr(SDAC_OFF_CTRL1, 8'h58);
      repeat (2000) @(posedge ref_clk);
      chk("mode outputs", 40'h00_00_30_7e_7d >> (32 - 8 * i) & 8'hff,
        {modulator_power, filter_power, gain_stage_power, ref_buf_pos_en,
        ref_buf_neg_en, filter_in_reset, reference_pair_sel});
      rd(SDAC_OFF_CTRL1, 40'h58_58_58_58_5a >> (32 - 8 * i),
         1'b1);
    end
    rd(SDAC_OFF_CTRL1, 8'h5a, 1'b1);
    finish_test();
  end
endmodule : tb_sdac_ctrl
